// [pkg/olfg_map.svh]
// Register offsets, field positions and reset values of the overlay format and geometry block.
`ifndef OLFG_MAP_SVH
`define OLFG_MAP_SVH

`define OLFG_NUM_REGS        8
`define OLFG_ADDR_CFG1       32'hF803_82D0
`define OLFG_ADDR_POS        32'hF803_82D4
`define OLFG_ADDR_SIZE       32'hF803_82D8
`define OLFG_ADDR_SRC        32'hF803_82DC
`define OLFG_ADDR_ROWP       32'hF803_82E0
`define OLFG_ADDR_PIXP       32'hF803_82E4
`define OLFG_ADDR_CROWP      32'hF803_82E8
`define OLFG_ADDR_CPIXP      32'hF803_82EC

`define OLFG_IDX_CFG1        0
`define OLFG_IDX_POS         1
`define OLFG_IDX_SIZE        2
`define OLFG_IDX_SRC         3
`define OLFG_IDX_ROWP        4
`define OLFG_IDX_PIXP        5
`define OLFG_IDX_CROWP       6
`define OLFG_IDX_CPIXP       7

`define OLFG_MASK_CFG1       32'h0003_F3F3
`define OLFG_MASK_XY         32'h07FF_07FF
`define OLFG_MASK_FULL       32'hFFFF_FFFF
`define OLFG_REG_RESET       32'h0000_0000

`define OLFG_LUT_EN_BIT      0
`define OLFG_CSPACE_BIT      1
`define OLFG_RGB_LSB         4
`define OLFG_LUTD_LSB        8
`define OLFG_YUV_LSB         12
`define OLFG_ROT_BIT         16
`define OLFG_SWP_BIT         17
`define OLFG_X_LSB           0
`define OLFG_Y_LSB           16

`endif

// [pkg/olfg_pkg.sv]
// Types shared by the overlay format and geometry block and its users.
package olfg_pkg;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [31:0] addr;
		logic [31:0] wdata;
	} olfg_bus_req_t;

	typedef struct packed {
		logic        chroma;
		logic [31:0] addr;
		logic [2:0]  bit_offset;
	} olfg_fetch_t;

	typedef struct packed {
		logic       lut_en;
		logic       yuv;
		logic [3:0] rgb_mode;
		logic [1:0] lut_depth;
		logic [3:0] yuv_mode;
		logic       rot;
		logic       swap;
		logic [2:0] bytes_per_pixel;
		logic [3:0] lut_bits;
		logic       split_chroma;
		logic       semiplanar;
		logic       sub420;
		logic [1:0] y0_lane;
		logic [1:0] y1_lane;
		logic [1:0] cb_lane;
		logic [1:0] cr_lane;
	} olfg_format_t;

	typedef enum logic [1:0] {
		OLFG_IDLE,
		OLFG_LUMA,
		OLFG_CHROMA
	} olfg_state_t;

endpackage

// [hdl/olfg_overlay.sv]
// Overlay layer format decode, window placement and source fetch address walker.
//
// What this block does
// RQ1: LUT bit selects direct RGB or indices.
// RQ2: Colour-space bit selects RGB or YUV.
// RQ3: RGB format field picks one of fourteen layouts.
// RQ4: LUT depth gives 1, 2, 4, 8 bits.
// RQ5: YUV 0 is 4:4:4; 1-4 packed orders.
// RQ6: YUV 5-8 are semiplanar and planar modes.
// RQ7: Rotation bit picks the rotation chroma upsampler.
// RQ8: Swap bit exchanges packed 4:2:2 luma samples.
// RQ9: Window position fields at bits 10:0, 26:16.
// RQ10: Window width is programmed value plus one.
// RQ11: Software keeps left plus width within line.
// RQ12: Window height is programmed value plus one.
// RQ13: Software keeps top plus height within frame.
// RQ14: Source width is programmed value plus one.
// RQ15: Source height is programmed value plus one.
// RQ16: Row pitch is added at each row end.
// RQ17: Pixel pitch is added between luma pixels.
// RQ18: Chroma row pitch added at chroma row end.
// RQ19: Chroma pixel pitch added between chroma samples.
// RQ20: Planar modes fetch chroma on separate channel.
// RQ21: Window origin is top-left active display pixel.
`timescale 1ns/1ps

`include "olfg_map.svh"

module olfg_overlay
	import olfg_pkg::*;
(
	input  wire logic          clk_sys,
	input  wire logic          rst_n,
	input  wire logic          clk_en,
	input  wire olfg_bus_req_t bus,
	output      logic [31:0]   rd_data,
	input  wire logic          frame_start,
	input  wire logic [31:0]   luma_base,
	input  wire logic [31:0]   chroma_base,
	input  wire logic          fetch_ready,
	output      logic          fetch_valid,
	output      olfg_fetch_t   fetch,
	input  wire logic [10:0]   disp_x,
	input  wire logic [10:0]   disp_y,
	output      logic          in_window,
	output      olfg_format_t  fmt
);

	localparam logic [31:0] REG_ADDR [`OLFG_NUM_REGS] = '{`OLFG_ADDR_CFG1, `OLFG_ADDR_POS, `OLFG_ADDR_SIZE,
		`OLFG_ADDR_SRC, `OLFG_ADDR_ROWP, `OLFG_ADDR_PIXP, `OLFG_ADDR_CROWP, `OLFG_ADDR_CPIXP};
	localparam logic [31:0] REG_MASK [`OLFG_NUM_REGS] = '{`OLFG_MASK_CFG1, `OLFG_MASK_XY, `OLFG_MASK_XY,
		`OLFG_MASK_XY, `OLFG_MASK_FULL, `OLFG_MASK_FULL, `OLFG_MASK_FULL, `OLFG_MASK_FULL};

	logic [31:0]  regs [`OLFG_NUM_REGS];
	logic [31:0]  cfg1;
	logic [10:0]  win_left;
	logic [10:0]  win_top;
	logic [10:0]  win_width_m1;
	logic [10:0]  win_height_m1;
	logic [10:0]  src_w_m1;
	logic [10:0]  src_h_m1;
	logic [31:0]  row_pitch;
	logic [31:0]  pixel_pitch;
	logic [31:0]  chroma_row_pitch;
	logic [31:0]  chroma_pixel_pitch;
	olfg_format_t next_fmt;
	olfg_state_t  state;
	logic [10:0]  x_cnt;
	logic [10:0]  y_cnt;
	logic [31:0]  luma_addr;
	logic [31:0]  chroma_addr;
	logic         hs;
	logic         last_x;
	logic         last_pix;
	logic         need_chroma;
	logic         chroma_row_end;
	logic [3:0]   next_bits;
	logic         byte_done;
	logic [31:0]  next_luma;
	logic [31:0]  next_chroma;
	logic [11:0]  win_right;
	logic [11:0]  win_bottom;

	// Register file: every register is plain read-write, reserved bits are masked to zero.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < `OLFG_NUM_REGS; i++) begin
				regs[i] <= `OLFG_REG_RESET;
			end
		end else if (clk_en && bus.wr) begin
			for (int i = 0; i < `OLFG_NUM_REGS; i++) begin
				if (bus.addr == REG_ADDR[i]) begin
					regs[i] <= bus.wdata & REG_MASK[i];
				end
			end
		end
	end

	// Read data stands only in the cycle after the strobe; unmapped addresses read zero.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rd_data <= `OLFG_REG_RESET;
		end else if (clk_en) begin
			rd_data <= `OLFG_REG_RESET;
			if (bus.rd) begin
				for (int i = 0; i < `OLFG_NUM_REGS; i++) begin
					if (bus.addr == REG_ADDR[i]) begin
						rd_data <= regs[i];
					end
				end
			end
		end
	end

	assign cfg1               = regs[`OLFG_IDX_CFG1];
	assign win_left           = regs[`OLFG_IDX_POS][`OLFG_X_LSB +: 11];       // see RQ9
	assign win_top            = regs[`OLFG_IDX_POS][`OLFG_Y_LSB +: 11];       // see RQ9
	assign win_width_m1       = regs[`OLFG_IDX_SIZE][`OLFG_X_LSB +: 11];
	assign win_height_m1      = regs[`OLFG_IDX_SIZE][`OLFG_Y_LSB +: 11];
	assign src_w_m1           = regs[`OLFG_IDX_SRC][`OLFG_X_LSB +: 11];
	assign src_h_m1           = regs[`OLFG_IDX_SRC][`OLFG_Y_LSB +: 11];
	assign row_pitch          = regs[`OLFG_IDX_ROWP];
	assign pixel_pitch        = regs[`OLFG_IDX_PIXP];
	assign chroma_row_pitch   = regs[`OLFG_IDX_CROWP];
	assign chroma_pixel_pitch = regs[`OLFG_IDX_CPIXP];

	// Format decode, registered so that downstream pixel units see a stable word.
	always_comb begin
		next_fmt              = '0;
		next_fmt.lut_en       = cfg1[`OLFG_LUT_EN_BIT];                     // see RQ1
		next_fmt.yuv          = cfg1[`OLFG_CSPACE_BIT];                     // see RQ2
		next_fmt.rgb_mode     = cfg1[`OLFG_RGB_LSB +: 4];
		next_fmt.lut_depth    = cfg1[`OLFG_LUTD_LSB +: 2];
		next_fmt.yuv_mode     = cfg1[`OLFG_YUV_LSB +: 4];
		next_fmt.rot          = cfg1[`OLFG_ROT_BIT];                        // see RQ7
		next_fmt.swap         = cfg1[`OLFG_SWP_BIT];
		next_fmt.lut_bits     = 4'h1 << cfg1[`OLFG_LUTD_LSB +: 2];          // see RQ4
		next_fmt.y0_lane      = 2'h0;
		next_fmt.y1_lane      = 2'h2;
		next_fmt.cb_lane      = 2'h1;
		next_fmt.cr_lane      = 2'h3;
		if (next_fmt.yuv) begin
			unique case (next_fmt.yuv_mode)
				4'h0: begin
					next_fmt.bytes_per_pixel = 3'h4;                          // see RQ5
				end
				4'h1: begin
					next_fmt.bytes_per_pixel = 3'h2;
				end
				4'h2: begin
					next_fmt.bytes_per_pixel = 3'h2;
					next_fmt.y0_lane         = 2'h1;
					next_fmt.y1_lane         = 2'h3;
					next_fmt.cb_lane         = 2'h0;
					next_fmt.cr_lane         = 2'h2;
				end
				4'h3: begin
					next_fmt.bytes_per_pixel = 3'h2;
					next_fmt.cb_lane         = 2'h3;
					next_fmt.cr_lane         = 2'h1;
				end
				4'h4: begin
					next_fmt.bytes_per_pixel = 3'h2;
					next_fmt.y0_lane         = 2'h1;
					next_fmt.y1_lane         = 2'h3;
					next_fmt.cb_lane         = 2'h2;
					next_fmt.cr_lane         = 2'h0;
				end
				4'h5, 4'h6, 4'h7, 4'h8: begin
					next_fmt.bytes_per_pixel = 3'h1;                          // see RQ6
					next_fmt.split_chroma    = 1'b1;
					next_fmt.semiplanar      = (next_fmt.yuv_mode == 4'h5) || (next_fmt.yuv_mode == 4'h7);
					next_fmt.sub420          = next_fmt.yuv_mode[3] || (next_fmt.yuv_mode == 4'h7);
				end
				default: begin
					next_fmt.bytes_per_pixel = 3'h4;
				end
			endcase
			// Swapping the two luma lanes happens before any sample is unpacked.
			if (next_fmt.swap && next_fmt.yuv_mode >= 4'h1 && next_fmt.yuv_mode <= 4'h4) begin
				{next_fmt.y0_lane, next_fmt.y1_lane} =
					{next_fmt.y1_lane, next_fmt.y0_lane};                     // see RQ8
			end
		end else if (!next_fmt.lut_en) begin
			unique case (next_fmt.rgb_mode)
				4'h0, 4'h1, 4'h2, 4'h3, 4'h4: begin
					next_fmt.bytes_per_pixel = 3'h2;                          // see RQ3
				end
				4'h6, 4'h8, 4'hA: begin
					next_fmt.bytes_per_pixel = 3'h3;
				end
				default: begin
					next_fmt.bytes_per_pixel = 3'h4;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			fmt <= '0;
		end else if (clk_en) begin
			fmt <= next_fmt;
		end
	end

	// Window hit test; the sums carry a spare bit so a misprogrammed window never wraps.
	assign win_right  = {1'b0, win_left} + {1'b0, win_width_m1};             // see RQ10
	assign win_bottom = {1'b0, win_top} + {1'b0, win_height_m1};             // see RQ12

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			in_window <= 1'b0;
		end else if (clk_en) begin
			// Coordinates count from the top-left active pixel; see RQ21
			in_window <= (disp_x >= win_left) && ({1'b0, disp_x} <= win_right)
				&& (disp_y >= win_top) && ({1'b0, disp_y} <= win_bottom);        // see RQ9
		end
	end

	// Address walker over the source image.
	assign hs             = clk_en && fetch_valid && fetch_ready;
	assign last_x         = (x_cnt == src_w_m1);                             // see RQ14
	assign last_pix       = last_x && (y_cnt == src_h_m1);                   // see RQ15
	assign need_chroma    = fmt.yuv && fmt.split_chroma && !x_cnt[0] && (!fmt.sub420 || !y_cnt[0]); // see RQ20
	assign chroma_row_end = ((x_cnt | 11'h001) >= src_w_m1);
	assign next_bits      = {1'b0, fetch.bit_offset} + fmt.lut_bits;
	assign byte_done      = next_bits[3] || last_x;

	always_comb begin
		next_luma = luma_addr;
		if (!fmt.yuv && fmt.lut_en) begin
			// Sub-byte indices share one byte; the pitch applies once that byte is used up.
			if (byte_done) begin
				next_luma = luma_addr + 32'h0000_0001 + (last_x ? row_pitch : pixel_pitch);
			end
		end else begin
			next_luma = luma_addr + {29'h0000_0000, fmt.bytes_per_pixel}
				+ (last_x ? row_pitch : pixel_pitch);                              // see RQ16 see RQ17
		end
	end

	assign next_chroma = chroma_addr + (fmt.semiplanar ? 32'h0000_0002 : 32'h0000_0001)
		+ (chroma_row_end ? chroma_row_pitch : chroma_pixel_pitch);             // see RQ18 see RQ19

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state       <= OLFG_IDLE;
			fetch_valid <= 1'b0;
			fetch       <= '0;
			x_cnt       <= 11'h000;
			y_cnt       <= 11'h000;
			luma_addr   <= 32'h0000_0000;
			chroma_addr <= 32'h0000_0000;
		end else if (clk_en) begin
			unique case (state)
				OLFG_IDLE: begin
					// A start while a frame is walking is ignored rather than restarting mid-frame.
					if (frame_start) begin
						state       <= OLFG_LUMA;
						fetch_valid <= 1'b1;
						fetch       <= '{chroma: 1'b0, addr: luma_base, bit_offset: 3'h0};
						luma_addr   <= luma_base;
						chroma_addr <= chroma_base;
						x_cnt       <= 11'h000;
						y_cnt       <= 11'h000;
					end
				end
				OLFG_LUMA: begin
					if (hs) begin
						luma_addr <= next_luma;
						if (need_chroma) begin
							state <= OLFG_CHROMA;
							fetch <= '{chroma: 1'b1, addr: chroma_addr, bit_offset: 3'h0};
						end else begin
							fetch.addr       <= next_luma;
							fetch.bit_offset <= (fmt.lut_en && !fmt.yuv && !byte_done) ? next_bits[2:0] : 3'h0;
							x_cnt            <= last_x ? 11'h000 : x_cnt + 11'h001;
							y_cnt            <= last_x ? y_cnt + 11'h001 : y_cnt;
							if (last_pix) begin
								state       <= OLFG_IDLE;
								fetch_valid <= 1'b0;
							end
						end
					end
				end
				OLFG_CHROMA: begin
					if (hs) begin
						chroma_addr <= next_chroma;
						fetch       <= '{chroma: 1'b0, addr: luma_addr, bit_offset: 3'h0};
						x_cnt       <= last_x ? 11'h000 : x_cnt + 11'h001;
						y_cnt       <= last_x ? y_cnt + 11'h001 : y_cnt;
						if (last_pix) begin
							state       <= OLFG_IDLE;
							fetch_valid <= 1'b0;
						end else begin
							state <= OLFG_LUMA;
						end
					end
				end
			endcase
		end
	end

	// Checks on the decode, the window and the walker.
	sequence s_luma_hs;
		hs && !fetch.chroma && state == OLFG_LUMA;
	endsequence

	sequence s_plain_step;
		s_luma_hs ##0 (!need_chroma && !fmt.lut_en && !fmt.yuv && !last_pix);
	endsequence

	property p_lut_bits;
		@(posedge clk_sys) disable iff (!rst_n)
		fmt.lut_en |-> fmt.lut_bits == (4'h1 << fmt.lut_depth);
	endproperty
	a_lut_bits: assert property (p_lut_bits) else $error("lut index width wrong"); // see RQ4

	property p_rgb565;
		@(posedge clk_sys) disable iff (!rst_n)
		(!fmt.lut_en && !fmt.yuv && fmt.rgb_mode == 4'h3) |-> fmt.bytes_per_pixel == 3'h2;
	endproperty
	a_rgb565: assert property (p_rgb565) else $error("rgb565 pixel size wrong"); // see RQ3

	property p_planar420;
		@(posedge clk_sys) disable iff (!rst_n)
		(fmt.yuv && fmt.yuv_mode == 4'h8) |-> fmt.split_chroma && fmt.sub420 && !fmt.semiplanar;
	endproperty
	a_planar420: assert property (p_planar420) else $error("planar 420 decode wrong"); // see RQ6

	property p_swap;
		@(posedge clk_sys) disable iff (!rst_n)
		(fmt.yuv && fmt.yuv_mode == 4'h1) |-> (fmt.swap ? (fmt.y0_lane == 2'h2 && fmt.y1_lane == 2'h0)
			: (fmt.y0_lane == 2'h0 && fmt.y1_lane == 2'h2));
	endproperty
	a_swap: assert property (p_swap) else $error("luma lanes not swapped as set"); // see RQ8

	property p_chroma_follows;
		@(posedge clk_sys) disable iff (!rst_n)
		(s_luma_hs ##0 need_chroma) |=> fetch_valid && fetch.chroma && fetch.addr == $past(chroma_addr);
	endproperty
	a_chroma_follows: assert property (p_chroma_follows) else $error("chroma fetch missing"); // see RQ20

	property p_pixel_step;
		@(posedge clk_sys) disable iff (!rst_n)
		(s_plain_step ##0 !last_x) |=> fetch.addr == $past(fetch.addr)
			+ {29'h0000_0000, $past(fmt.bytes_per_pixel)} + $past(pixel_pitch);
	endproperty
	a_pixel_step: assert property (p_pixel_step) else $error("pixel pitch not applied"); // see RQ17

	property p_row_step;
		@(posedge clk_sys) disable iff (!rst_n)
		(s_plain_step ##0 last_x) |=> fetch.addr == $past(fetch.addr)
			+ {29'h0000_0000, $past(fmt.bytes_per_pixel)} + $past(row_pitch) && x_cnt == 11'h000;
	endproperty
	a_row_step: assert property (p_row_step) else $error("row pitch not applied"); // see RQ16

	property p_frame_end;
		@(posedge clk_sys) disable iff (!rst_n)
		(hs && last_pix && !need_chroma) |=> !fetch_valid && state == OLFG_IDLE;
	endproperty
	a_frame_end: assert property (p_frame_end) else $error("walk did not stop at last pixel"); // see RQ15

	property p_win_edge;
		@(posedge clk_sys) disable iff (!rst_n)
		(clk_en && disp_y == win_top && {1'b0, disp_x} == win_right) |=> in_window;
	endproperty
	a_win_edge: assert property (p_win_edge) else $error("last window column missed"); // see RQ10

endmodule // olfg_overlay

// [tb/olfg_mem_model.sv]
// Memory-side partner that accepts fetch requests at full rate or with stalls.
`timescale 1ns/1ps

module olfg_mem_model
	import olfg_pkg::*;
(
	input  wire logic clk_sys,
	input  wire logic rst_n,
	input  wire logic slow,
	input  wire logic fetch_valid,
	output      logic fetch_ready
);
	logic [1:0] stall_cnt;

	// A slow memory only accepts one request in four cycles, so requests must hold while waiting.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			stall_cnt <= 2'h0;
		end else begin
			stall_cnt <= stall_cnt + 2'h1;
		end
	end

	assign fetch_ready = rst_n && (!slow || (stall_cnt == 2'h3));

endmodule // olfg_mem_model

// [tb/tb.sv]
// Self-checking testbench of the overlay format and geometry block.
`timescale 1ns/1ps
`include "olfg_map.svh"

module tb
	import olfg_pkg::*;
;
	typedef struct packed {logic [31:0] a; logic [31:0] w; logic [31:0] e;} olfg_row_t;

	logic          clk_sys     = 1'b0;
	logic          rst_n       = 1'b0;
	logic          clk_en      = 1'b1;
	logic          frame_start = 1'b0;
	logic          slow        = 1'b0;
	logic [31:0]   luma_base   = 32'h0000_0000;
	logic [31:0]   chroma_base = 32'h0000_0000;
	logic [10:0]   disp_x      = 11'h000;
	logic [10:0]   disp_y      = 11'h000;
	olfg_bus_req_t bus         = '0;
	logic [31:0]   rd_data;
	logic          fetch_ready;
	logic          fetch_valid;
	logic          in_window;
	olfg_fetch_t   fetch;
	olfg_format_t  fmt;
	int            mismatches  = 0;
	int            n_checks    = 0;
	int            cycles      = 0;
	logic [32:0]   expq[$];
	logic [32:0]   obsq[$];
	olfg_row_t     rows[9]     = '{
		'{`OLFG_ADDR_CFG1,  32'hFFFF_FFFF, `OLFG_MASK_CFG1},
		'{`OLFG_ADDR_POS,   32'hFFFF_FFFF, `OLFG_MASK_XY},
		'{`OLFG_ADDR_SIZE,  32'hFFFF_FFFF, `OLFG_MASK_XY},
		'{`OLFG_ADDR_SRC,   32'hFFFF_FFFF, `OLFG_MASK_XY},
		'{`OLFG_ADDR_ROWP,  32'h1234_5678, 32'h1234_5678},
		'{`OLFG_ADDR_PIXP,  32'h8765_4321, 32'h8765_4321},
		'{`OLFG_ADDR_CROWP, 32'hDEAD_BEEF, 32'hDEAD_BEEF},
		'{`OLFG_ADDR_CPIXP, 32'h0BAD_F00D, 32'h0BAD_F00D},
		'{32'hF803_82F0,    32'hFFFF_FFFF, 32'h0000_0000}};

	olfg_overlay dut (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .bus(bus), .rd_data(rd_data),
		.frame_start(frame_start), .luma_base(luma_base), .chroma_base(chroma_base),
		.fetch_ready(fetch_ready), .fetch_valid(fetch_valid), .fetch(fetch), .disp_x(disp_x),
		.disp_y(disp_y), .in_window(in_window), .fmt(fmt));

	olfg_mem_model mem (.clk_sys(clk_sys), .rst_n(rst_n), .slow(slow), .fetch_valid(fetch_valid),
		.fetch_ready(fetch_ready));

	always #12.5 clk_sys = ~clk_sys;

	always @(posedge clk_sys) begin
		if (fetch_valid && fetch_ready && clk_en) begin
			obsq.push_back({fetch.chroma, fetch.addr});
		end
	end

	task automatic test_done();
		if (mismatches == 0 && n_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// The run should take a few hundred cycles; a hang is cut off well beyond that.
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			test_done();
		end
	end

	task automatic chk(input logic [32:0] got, input logic [32:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] w);
		@(posedge clk_sys);
		bus <= '{1'b1, 1'b0, a, w};
		@(posedge clk_sys);
		bus <= '0;
	endtask

	task automatic rd(input logic [31:0] a, output logic [31:0] d);
		@(posedge clk_sys);
		bus <= '{1'b0, 1'b1, a, 32'h0000_0000};
		@(posedge clk_sys);
		bus <= '0;
		#1;
		d = rd_data;
	endtask

	task automatic win(input logic [10:0] x, input logic [10:0] y, input logic exp);
		@(posedge clk_sys);
		disp_x <= x;
		disp_y <= y;
		@(posedge clk_sys);
		#1;
		chk(33'(in_window), 33'(exp));
	endtask

	// The expected fetch list is built from the strides; a second start mid-frame must be ignored.
	task automatic walk(input logic [31:0] cfg, input int wm1, input int hm1, input int bpp, input bit split,
		input bit sub, input bit semi, input logic [31:0] pp, input logic [31:0] rp, input bit sl);
		logic [31:0] l;
		logic [31:0] c;
		int k;
		l = 32'h0001_0000;
		c = 32'h0002_0000;
		expq.delete();
		for (int y = 0; y <= hm1; y++) begin
			for (int x = 0; x <= wm1; x++) begin
				expq.push_back({1'b0, l});
				if (split && x % 2 == 0 && (!sub || y % 2 == 0)) begin
					expq.push_back({1'b1, c});
					c += (semi ? 2 : 1) + (((x | 1) >= wm1) ? 32'h0000_0040 : 32'h0000_0004);
				end
				l += bpp + ((x == wm1) ? rp : pp);
			end
		end
		wr(`OLFG_ADDR_CFG1, cfg);
		wr(`OLFG_ADDR_SRC, (32'(hm1) << 16) | 32'(wm1));
		wr(`OLFG_ADDR_PIXP, pp);
		wr(`OLFG_ADDR_ROWP, rp);
		wr(`OLFG_ADDR_CPIXP, 32'h0000_0004);
		wr(`OLFG_ADDR_CROWP, 32'h0000_0040);
		@(posedge clk_sys);
		slow <= sl;
		obsq.delete();
		frame_start <= 1'b1;
		luma_base <= 32'h0001_0000;
		chroma_base <= 32'h0002_0000;
		@(posedge clk_sys);
		frame_start <= 1'b0;
		repeat (3) @(posedge clk_sys);
		frame_start <= 1'b1;
		luma_base <= 32'h0005_0000;
		@(posedge clk_sys);
		frame_start <= 1'b0;
		k = 0;
		while (fetch_valid !== 1'b0 && k < 2000) begin
			@(posedge clk_sys);
			k++;
		end
		chk(33'(k < 2000), 33'h0_0000_0001);
		chk(33'(obsq.size()), 33'(expq.size()));
		for (int i = 0; i < expq.size() && i < obsq.size(); i++) begin
			chk(obsq[i], expq[i]);
		end
	endtask

	initial begin
		logic [31:0] d;
		logic [7:0]  e;
		logic [7:0]  lanes[5];
		lanes = '{8'h00, 8'h27, 8'h72, 8'h2D, 8'h78};
		repeat (8) @(posedge clk_sys);
		rst_n <= 1'b1;
		foreach (rows[i]) begin
			rd(rows[i].a, d);
			chk(33'(d), 33'h0_0000_0000);
		end
		foreach (rows[i]) begin
			wr(rows[i].w == 32'hFFFF_FFFF ? rows[i].a : rows[i].a, rows[i].w);
			rd(rows[i].a, d);
			chk(33'(d), 33'(rows[i].e));
		end
		rd(`OLFG_ADDR_ROWP, d);
		chk(33'(d), 33'h0_1234_5678);
		@(posedge clk_sys);
		#1;
		chk(33'(rd_data), 33'h0_0000_0000);
		for (int m = 0; m < 14; m++) begin
			wr(`OLFG_ADDR_CFG1, 32'(m) << 4);
			@(posedge clk_sys);
			#1;
			chk(33'(fmt.rgb_mode), 33'(m));
			chk(33'(fmt.bytes_per_pixel), (m <= 4) ? 33'h2 : ((m == 6 || m == 8 || m == 10) ? 33'h3 : 33'h4));
			chk(33'({fmt.lut_en, fmt.yuv}), 33'h0);
		end
		for (int m = 0; m < 4; m++) begin
			wr(`OLFG_ADDR_CFG1, 32'h0000_0001 | (32'(m) << 8));
			@(posedge clk_sys);
			#1;
			chk(33'({fmt.lut_en, fmt.lut_depth, fmt.lut_bits}), 33'({1'b1, 2'(m), 4'(1 << m)}));
			chk(33'(fmt.bytes_per_pixel), 33'h0);
		end
		for (int m = 0; m < 9; m++) begin
			wr(`OLFG_ADDR_CFG1, 32'h0000_0002 | (32'(m) << 12) | (32'(m % 2) << 17) | (32'(1 - m % 2) << 16));
			@(posedge clk_sys);
			#1;
			chk(33'({fmt.yuv, fmt.yuv_mode, fmt.swap, fmt.rot}), 33'({1'b1, 4'(m), m % 2 == 1, m % 2 == 0}));
			chk(33'({fmt.split_chroma, fmt.semiplanar, fmt.sub420}), 33'({m >= 5, m == 5 || m == 7, m >= 7}));
			chk(33'(fmt.bytes_per_pixel), (m == 0) ? 33'h4 : ((m <= 4) ? 33'h2 : 33'h1));
			e = (m % 2 == 1) ? {lanes[m % 5][5:4], lanes[m % 5][7:6], lanes[m % 5][3:0]} : lanes[m % 5];
			if (m >= 1 && m <= 4) begin
				chk(33'({fmt.y0_lane, fmt.y1_lane, fmt.cb_lane, fmt.cr_lane}), 33'(e));
			end
		end
		// Software keeps left plus width and top plus height inside the display.
		wr(`OLFG_ADDR_POS, 32'h0003_0005);
		wr(`OLFG_ADDR_SIZE, 32'h0001_0002);
		win(11'h005, 11'h003, 1'b1);
		win(11'h007, 11'h003, 1'b1);
		win(11'h007, 11'h004, 1'b1);
		win(11'h008, 11'h004, 1'b0);
		win(11'h004, 11'h003, 1'b0);
		win(11'h005, 11'h005, 1'b0);
		win(11'h007, 11'h002, 1'b0);
		// A write made while the clock enable is low must leave the register untouched.
		@(posedge clk_sys);
		clk_en <= 1'b0;
		wr(`OLFG_ADDR_POS, 32'h0000_0000);
		clk_en <= 1'b1;
		rd(`OLFG_ADDR_POS, d);
		chk(33'(d), 33'h0_0003_0005);
		walk(32'h0000_0030, 2, 1, 2, 0, 0, 0, 32'h0000_0004, 32'hFFFF_FFF8, 1'b0);
		walk(32'h0000_7002, 3, 2, 1, 1, 1, 1, 32'h0000_0002, 32'h0000_0010, 1'b1);
		walk(32'h0000_6002, 3, 1, 1, 1, 0, 0, 32'h0000_0000, 32'h0000_0020, 1'b0);
		walk(32'h0000_0301, 1, 1, 1, 0, 0, 0, 32'h0000_0003, 32'h0000_0008, 1'b1);
		@(posedge clk_sys);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		rd(`OLFG_ADDR_POS, d);
		chk(33'(d), 33'h0_0000_0000);
		test_done();
	end

endmodule // tb
